/* File: ldri_reset_ctrl.sv */
// Reset, software reset and contrast register control with an AHB-Lite register port
`timescale 1ns/1ps
`include "ldri_defines.svh"

module ldri_reset_ctrl #(
    parameter bit HIGH_VOLT = 1'b0,
    parameter int INIT_CYCLES = `LDRI_INIT_CYCLES,
    parameter int SERIAL_WIDTH = 8
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic hardware_reset_pin_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic serialBit,
    input wire logic serialStrobe,
    output ldri_pkg::ldri_ctrl_t displayCfg,
    output logic [5:0] startLine,
    output logic [7:0] column,
    output logic [3:0] page,
    output logic [4:0] volume,
    output logic busy,
    output logic resetActive,
    output logic [SERIAL_WIDTH-1:0] serialByte,
    output logic serialValid,
    output logic lcd_ac_frame_signal,
    output logic display_clock_output,
    output logic common_start_pulse_output
);
    // ==================================================
    // Reset pin and serial input
    logic initRstN;

    ldri_rst_sync uSync (
        .clock(clock),
        .rst_n(rst_n),
        .hardware_reset_pin_n(hardware_reset_pin_n),
        .initRstN(initRstN)
    );

    ldri_serial_in #(
        .WIDTH(SERIAL_WIDTH)
    ) uSerial (
        .clock(clock),
        .initRstN(initRstN),
        .serialBit(serialBit),
        .serialStrobe(serialStrobe),
        .serialByte(serialByte),
        .serialValid(serialValid)
    );

    // ==================================================
    // Bus decode
    ldri_pkg::ldri_phase_t phase_r;
    ldri_pkg::ldri_state_t state_r;
    ldri_pkg::ldri_ctrl_t ctrl_r;
    ldri_pkg::ldri_ctrl_t ctrl_nxt;
    logic [15:0] initCnt_r;
    logic [5:0] startLine_r;
    logic [5:0] startLine_nxt;
    logic [7:0] column_r;
    logic [7:0] column_nxt;
    logic [3:0] page_r;
    logic [3:0] page_nxt;
    logic [4:0] volume_r;
    logic [4:0] volume_nxt;
    logic [31:0] hrdata_r;
    logic [31:0] rdMux;
    logic [31:0] ctrlWord;

    wire addrPhase = hsel & htrans[1] & hready;
    wire isBusy = (state_r != ldri_pkg::ST_RUN);
    // Commands arriving while busy are dropped, not queued
    wire wrEn = phase_r.wr & ~isBusy;
    wire rdEn = phase_r.rd & ~isBusy;
    wire wrCtrl = wrEn && (phase_r.addr == `LDRI_OFF_CTRL);
    wire wrSwrst = wrEn && (phase_r.addr == `LDRI_OFF_SWRST) && hwdata[`LDRI_BIT_SWRST];
    wire wrStart = wrEn && (phase_r.addr == `LDRI_OFF_START);
    wire wrColumn = wrEn && (phase_r.addr == `LDRI_OFF_COLUMN);
    wire wrPage = wrEn && (phase_r.addr == `LDRI_OFF_PAGE);
    wire wrVolume = wrEn && (phase_r.addr == `LDRI_OFF_VOLUME);
    wire wrData = wrEn && (phase_r.addr == `LDRI_OFF_DATA);
    wire rdData = rdEn && (phase_r.addr == `LDRI_OFF_DATA);
    // Read-modify-write freezes the counter on reads only
    wire colStep = wrData | (rdData & ~ctrl_r.rmwMode);
    wire swApply = wrSwrst;

    always_ff @(posedge clock or negedge initRstN) begin
        if (!initRstN) begin
            phase_r <= '0;
            hrdata_r <= 32'h0000_0000;
        end else begin
            phase_r.wr <= addrPhase & hwrite;
            phase_r.rd <= addrPhase & ~hwrite;
            phase_r.addr <= haddr[7:0];
            if (addrPhase & ~hwrite) begin
                hrdata_r <= rdMux;
            end
        end
    end

    // Zero wait states: every transfer completes in its data phase
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;

    // ==================================================
    // Read mux
    always_comb begin
        ctrlWord = 32'h0000_0000;
        ctrlWord[`LDRI_BIT_DISP_ON] = ctrl_r.displayOn;
        ctrlWord[`LDRI_BIT_REVERSE] = ctrl_r.reverse;
        ctrlWord[`LDRI_BIT_SEG_REV] = ctrl_r.segReverse;
        ctrlWord[`LDRI_BIT_RMW] = ctrl_r.rmwMode;
        ctrlWord[`LDRI_BIT_STATIC] = ctrl_r.staticInd;
        ctrlWord[`LDRI_BIT_TEST] = ctrl_r.testMode;
        ctrlWord[`LDRI_BIT_COM_REV] = ctrl_r.comReverse;
        ctrlWord[`LDRI_BIT_PWR +: 3] = ctrl_r.powerCtrl;
        ctrlWord[`LDRI_BIT_BIAS] = ctrl_r.biasHigh;
    end

    always_comb begin
        rdMux = 32'h0000_0000;
        case (haddr[7:0])
            `LDRI_OFF_CTRL: rdMux = ctrlWord;
            `LDRI_OFF_STATUS: begin
                rdMux[`LDRI_STS_BUSY] = isBusy;
                rdMux[`LDRI_STS_SEG_REV] = ctrl_r.segReverse;
                rdMux[`LDRI_STS_OFF] = ~ctrl_r.displayOn;
                rdMux[`LDRI_STS_RESET] = isBusy;
            end
            `LDRI_OFF_START: rdMux[5:0] = startLine_r;
            `LDRI_OFF_COLUMN: rdMux[7:0] = column_r;
            `LDRI_OFF_PAGE: rdMux[3:0] = page_r;
            `LDRI_OFF_VOLUME: rdMux[4:0] = volume_r;
            `LDRI_OFF_SERIAL: rdMux[SERIAL_WIDTH-1:0] = serialByte;
            default: rdMux = 32'h0000_0000;
        endcase
    end

    // ==================================================
    // Next-state of the settings
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wrCtrl) begin
            ctrl_nxt.displayOn = hwdata[`LDRI_BIT_DISP_ON];
            ctrl_nxt.reverse = hwdata[`LDRI_BIT_REVERSE];
            ctrl_nxt.segReverse = hwdata[`LDRI_BIT_SEG_REV];
            ctrl_nxt.rmwMode = hwdata[`LDRI_BIT_RMW];
            ctrl_nxt.staticInd = hwdata[`LDRI_BIT_STATIC];
            ctrl_nxt.testMode = hwdata[`LDRI_BIT_TEST];
            ctrl_nxt.comReverse = hwdata[`LDRI_BIT_COM_REV];
            ctrl_nxt.powerCtrl = hwdata[`LDRI_BIT_PWR +: 3];
            ctrl_nxt.biasHigh = hwdata[`LDRI_BIT_BIAS];
        end
        // Display, segment direction, power and bias survive a software reset; common direction is cleared
        if (swApply) begin
            ctrl_nxt.staticInd = 1'b0;
            ctrl_nxt.comReverse = 1'b0;
            ctrl_nxt.testMode = 1'b0;
        end
    end

    always_comb begin
        startLine_nxt = wrStart ? hwdata[5:0] : startLine_r;
        page_nxt = wrPage ? hwdata[3:0] : page_r;
        volume_nxt = wrVolume ? hwdata[4:0] : volume_r;
        column_nxt = column_r;
        if (wrColumn) begin
            column_nxt = hwdata[7:0];
        end else if (colStep && column_r < `LDRI_COLUMN_MAX) begin
            column_nxt = column_r + 8'h01;
        end
        if (swApply) begin
            startLine_nxt = `LDRI_START_RST;
            column_nxt = `LDRI_COLUMN_RST;
            page_nxt = `LDRI_PAGE_RST;
            volume_nxt = `LDRI_VOLUME_RST;
        end
    end

    // ==================================================
    // Settings registers
    always_ff @(posedge clock or negedge initRstN) begin
        if (!initRstN) begin
            ctrl_r.displayOn <= 1'b0;
            ctrl_r.reverse <= 1'b0;
            ctrl_r.segReverse <= 1'b0;
            ctrl_r.rmwMode <= 1'b0;
            ctrl_r.staticInd <= 1'b0;
            ctrl_r.testMode <= 1'b0;
            ctrl_r.comReverse <= 1'b0;
            ctrl_r.powerCtrl <= `LDRI_PWR_RST;
            ctrl_r.biasHigh <= HIGH_VOLT;
            startLine_r <= `LDRI_START_RST;
            column_r <= `LDRI_COLUMN_RST;
            page_r <= `LDRI_PAGE_RST;
            volume_r <= `LDRI_VOLUME_RST;
        end else begin
            ctrl_r <= ctrl_nxt;
            startLine_r <= startLine_nxt;
            column_r <= column_nxt;
            page_r <= page_nxt;
            volume_r <= volume_nxt;
        end
    end

    // ==================================================
    // Initialisation sequencer
    always_ff @(posedge clock or negedge initRstN) begin
        if (!initRstN) begin
            state_r <= ldri_pkg::ST_HWINIT;
            initCnt_r <= 16'(INIT_CYCLES);
        end else begin
            case (state_r)
                ldri_pkg::ST_RUN: begin
                    if (swApply) begin
                        state_r <= ldri_pkg::ST_SWINIT;
                        initCnt_r <= 16'(INIT_CYCLES);
                    end
                end
                ldri_pkg::ST_HWINIT, ldri_pkg::ST_SWINIT: begin
                    if (initCnt_r <= 16'h0001) begin
                        state_r <= ldri_pkg::ST_RUN;
                        initCnt_r <= 16'h0000;
                    end else begin
                        initCnt_r <= initCnt_r - 16'h0001;
                    end
                end
                default: state_r <= ldri_pkg::ST_RUN;
            endcase
        end
    end

    assign busy = isBusy;
    assign resetActive = isBusy;
    assign displayCfg = ctrl_r;
    assign startLine = startLine_r;
    assign column = column_r;
    assign page = page_r;
    assign volume = volume_r;

    // ==================================================
    // Display timing, untouched by the reset pin
    logic [15:0] divCnt_r;
    logic [7:0] lineCnt_r;
    logic dispClk_r;
    logic frame_r;
    logic startPulse_r;
    wire divWrap = (divCnt_r == `LDRI_DIV_HALF - 16'h0001);
    wire lineEnd = divWrap & dispClk_r;
    wire frameEnd = lineEnd && (lineCnt_r == `LDRI_FRAME_LINES - 8'h01);

    // Only the system reset stops the timing chain
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            divCnt_r <= 16'h0000;
            lineCnt_r <= 8'h00;
            dispClk_r <= 1'b0;
            frame_r <= 1'b0;
            startPulse_r <= 1'b0;
        end else begin
            divCnt_r <= divWrap ? 16'h0000 : divCnt_r + 16'h0001;
            dispClk_r <= dispClk_r ^ divWrap;
            if (lineEnd) begin
                lineCnt_r <= frameEnd ? 8'h00 : lineCnt_r + 8'h01;
            end
            frame_r <= frame_r ^ frameEnd;
            startPulse_r <= frameEnd;
        end
    end

    assign lcd_ac_frame_signal = frame_r;
    assign display_clock_output = dispClk_r;
    assign common_start_pulse_output = startPulse_r;

    // ==================================================
    // Checks
    AST_HW_DISPLAY: assert property (
        @(posedge clock) disable iff (!rst_n)
        !initRstN |-> (!displayCfg.displayOn && !displayCfg.reverse && !displayCfg.segReverse
        && !displayCfg.rmwMode && displayCfg.powerCtrl == 3'h0
        && displayCfg.biasHigh == HIGH_VOLT))
        else $error("Display settings not at reset state");
    AST_HW_ADDRESS: assert property (
        @(posedge clock) disable iff (!rst_n)
        !initRstN |-> (startLine == 6'h01 && column == 8'h00 && page == 4'h0
        && volume == 5'h00 && !displayCfg.comReverse))
        else $error("Address or volume registers not at reset state");
    AST_HW_SERIAL: assert property (
        @(posedge clock) disable iff (!rst_n)
        !initRstN |-> (serialByte == '0 && !serialValid))
        else $error("Serial register not cleared on reset");
    AST_OSC_RUNS: assert property (
        @(posedge clock) disable iff (!rst_n)
        (!initRstN && !divWrap) |=> divCnt_r == $past(divCnt_r) + 16'h0001)
        else $error("Display timing stopped by reset pin");
    AST_SW_KEEPS: assert property (
        @(posedge clock) disable iff (!initRstN)
        swApply |=> (displayCfg.displayOn == $past(ctrl_r.displayOn)
        && displayCfg.powerCtrl == $past(ctrl_r.powerCtrl) && startLine == 6'h01
        && volume == 5'h00 && column == 8'h00 && busy))
        else $error("Software reset touched wrong settings");
    AST_VOL_WRITE: assert property (
        @(posedge clock) disable iff (!initRstN)
        wrVolume |=> volume == $past(hwdata[4:0]))
        else $error("Volume write not stored");
    AST_PWR_FIELD: assert property (
        @(posedge clock) disable iff (!initRstN)
        wrCtrl |=> displayCfg.powerCtrl == $past(hwdata[`LDRI_BIT_PWR +: 3]))
        else $error("Power control field not stored");
    AST_BUSY_REJECT: assert property (
        @(posedge clock) disable iff (!initRstN)
        (busy && phase_r.wr && phase_r.addr == `LDRI_OFF_VOLUME) |=> $stable(volume))
        else $error("Command accepted while busy");
    AST_INIT_HOLD: assert property (
        @(posedge clock) disable iff (!rst_n)
        $rose(initRstN) |-> resetActive [*8])
        else $error("Reset status dropped too early");
    AST_INIT_DONE: assert property (
        @(posedge clock) disable iff (!initRstN)
        $rose(initRstN) |-> ##[1:1000] !resetActive)
        else $error("Initialisation never completed");
endmodule

/* File: ldri_defines.svh */
// Offsets, field positions, reset values and timing counts of the reset and volume block
`ifndef LDRI_DEFINES_SVH
`define LDRI_DEFINES_SVH
// ==================================================
// Timing
`define LDRI_CLK_PERIOD_PS 5000
`define LDRI_INIT_TIME_NS 100
`define LDRI_INIT_CYCLES ((`LDRI_INIT_TIME_NS * 1000 + `LDRI_CLK_PERIOD_PS - 1) / `LDRI_CLK_PERIOD_PS)
`define LDRI_DIV_HALF 16'h0010
`define LDRI_FRAME_LINES 8'h21
// ==================================================
// Register byte offsets
`define LDRI_OFF_CTRL 8'h00
`define LDRI_OFF_SWRST 8'h04
`define LDRI_OFF_STATUS 8'h08
`define LDRI_OFF_START 8'h0C
`define LDRI_OFF_COLUMN 8'h10
`define LDRI_OFF_PAGE 8'h14
`define LDRI_OFF_VOLUME 8'h18
`define LDRI_OFF_SERIAL 8'h1C
`define LDRI_OFF_DATA 8'h20
// ==================================================
// Field positions
`define LDRI_BIT_DISP_ON 0
`define LDRI_BIT_REVERSE 1
`define LDRI_BIT_SEG_REV 2
`define LDRI_BIT_RMW 3
`define LDRI_BIT_STATIC 4
`define LDRI_BIT_TEST 5
`define LDRI_BIT_COM_REV 6
`define LDRI_BIT_PWR 8
`define LDRI_BIT_BIAS 12
`define LDRI_BIT_SWRST 0
`define LDRI_STS_BUSY 7
`define LDRI_STS_SEG_REV 6
`define LDRI_STS_OFF 5
`define LDRI_STS_RESET 4
// ==================================================
// Reset values and limits
`define LDRI_START_RST 6'h01
`define LDRI_COLUMN_RST 8'h00
`define LDRI_PAGE_RST 4'h0
`define LDRI_VOLUME_RST 5'h00
`define LDRI_PWR_RST 3'h0
`define LDRI_COLUMN_MAX 8'h83
`endif

/* File: ldri_pkg.sv */
// Types shared by the reset and volume block
package ldri_pkg;
    typedef struct packed {
        logic displayOn;
        logic reverse;
        logic segReverse;
        logic rmwMode;
        logic staticInd;
        logic testMode;
        logic comReverse;
        logic [2:0] powerCtrl;
        logic biasHigh;
    } ldri_ctrl_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
    } ldri_phase_t;

    typedef enum logic [1:0] {ST_RUN, ST_HWINIT, ST_SWINIT} ldri_state_t;
endpackage

/* File: ldri_rst_sync.sv */
// Reset pin synchroniser: asserts at once, releases on the clock
`timescale 1ns/1ps
module ldri_rst_sync (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic hardware_reset_pin_n,
    output logic initRstN
);
    logic meta_r;
    logic hold_r;
    wire arstN = rst_n & hardware_reset_pin_n;

    always_ff @(posedge clock or negedge arstN) begin
        if (!arstN) begin
            meta_r <= 1'b0;
            hold_r <= 1'b0;
        end else begin
            meta_r <= 1'b1;
            hold_r <= meta_r;
        end
    end

    assign initRstN = hold_r;
endmodule

/* File: ldri_serial_in.sv */
// Serial command input register, most significant bit first
`timescale 1ns/1ps
module ldri_serial_in #(
    parameter int WIDTH = 8
) (
    input wire logic clock,
    input wire logic initRstN,
    input wire logic serialBit,
    input wire logic serialStrobe,
    output logic [WIDTH-1:0] serialByte,
    output logic serialValid
);
    localparam int CW = $clog2(WIDTH);
    logic [WIDTH-1:0] shift_r;
    logic [CW-1:0] cnt_r;
    wire last = (cnt_r == CW'(WIDTH - 1));

    // A half-shifted byte is dropped on reset
    always_ff @(posedge clock or negedge initRstN) begin
        if (!initRstN) begin
            shift_r <= '0;
            cnt_r <= '0;
            serialByte <= '0;
            serialValid <= 1'b0;
        end else begin
            serialValid <= serialStrobe & last;
            if (serialStrobe) begin
                shift_r <= {shift_r[WIDTH-2:0], serialBit};
                cnt_r <= last ? '0 : cnt_r + 1'b1;
                if (last) begin
                    serialByte <= {shift_r[WIDTH-2:0], serialBit};
                end
            end
        end
    end
endmodule

/* File: ldri_host_model.sv */
// Host processor model: AHB-Lite single-word master and reset pin driver
`timescale 1ns/1ps
module ldri_host_model (
    input wire logic clock,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    output logic hardware_reset_pin_n
);
    // ==================================================
    // Power-up state
    initial begin
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
        hardware_reset_pin_n = 1'b0;
    end

    // ==================================================
    // Reset pin
    task automatic pin_low;
        @(posedge clock);
        hardware_reset_pin_n <= 1'b0;
    endtask

    task automatic pin_high;
        @(posedge clock);
        hardware_reset_pin_n <= 1'b1;
    endtask

    // ==================================================
    // One single transfer, waits on hready in both phases
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0000_00, a};
        hwrite <= w;
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        // Read data phase shows a changing pattern, not stale data
        hwdata <= w ? d : ~hwdata;
        do @(posedge clock); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
endmodule

/* File: lcd_driver_reset_and_volume_init_tb_top.sv */
// Self-checking bench for the reset and contrast volume block
`timescale 1ns/1ps
`include "ldri_defines.svh"
module lcd_driver_reset_and_volume_init_tb_top;
    // ==================================================
    // Signals
    localparam int INIT = 20;
    localparam logic [31:0] MASK = 32'h0000_177F;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic serialBit = 1'b0;
    logic serialStrobe = 1'b0;
    logic hsel, hwrite, hardware_reset_pin_n, hreadyout, hresp, busy, resetActive, serialValid;
    logic [31:0] haddr, hwdata, hrdata, q, w, seed;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [5:0] startLine;
    logic [7:0] column, serialByte;
    logic [3:0] page;
    logic [4:0] volume, v;
    logic lcd_ac_frame_signal, display_clock_output, common_start_pulse_output, prev, prevFr;
    ldri_pkg::ldri_ctrl_t displayCfg;
    ldri_pkg::ldri_ctrl_t cfgHv;
    logic [4:0] corner [4] = '{5'h1F, 5'h10, 5'h0F, 5'h00};
    int n_errors = 0;
    int n_compared = 0;
    int n, tog, nFr, nSp;

    initial begin
        forever #2.5 clock = ~clock;
    end

    ldri_host_model u_host (.clock(clock), .hreadyout(hreadyout), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hardware_reset_pin_n(hardware_reset_pin_n));

    ldri_reset_ctrl #(.HIGH_VOLT(1'b0), .INIT_CYCLES(INIT), .SERIAL_WIDTH(8)) u_dut (
        .clock(clock), .rst_n(rst_n), .hardware_reset_pin_n(hardware_reset_pin_n),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .serialBit(serialBit), .serialStrobe(serialStrobe),
        .displayCfg(displayCfg), .startLine(startLine), .column(column), .page(page),
        .volume(volume), .busy(busy), .resetActive(resetActive), .serialByte(serialByte),
        .serialValid(serialValid), .lcd_ac_frame_signal(lcd_ac_frame_signal),
        .display_clock_output(display_clock_output),
        .common_start_pulse_output(common_start_pulse_output));

    // Second copy for the higher-voltage bias default; never addressed
    ldri_reset_ctrl #(.HIGH_VOLT(1'b1), .INIT_CYCLES(INIT), .SERIAL_WIDTH(8)) u_dut_hv (
        .clock(clock), .rst_n(rst_n), .hardware_reset_pin_n(hardware_reset_pin_n),
        .hsel(1'b0), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(), .hresp(), .hrdata(),
        .serialBit(serialBit), .serialStrobe(serialStrobe), .displayCfg(cfgHv),
        .startLine(), .column(), .page(), .volume(), .busy(), .resetActive(),
        .serialByte(), .serialValid(), .lcd_ac_frame_signal(), .display_clock_output(),
        .common_start_pulse_output());

    // ==================================================
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    function automatic ldri_pkg::ldri_ctrl_t cfg_of(input logic [31:0] c);
        return {c[0], c[1], c[2], c[3], c[4], c[5], c[6], c[10:8], c[12]};
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tick;
        @(posedge clock);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        u_host.xfer(1'b1, a, d, r);
    endtask

    task automatic wait_idle(output int k);
        k = 0;
        tick();
        while (busy !== 1'b0 && k < 200) begin
            tick();
            k++;
        end
        if (k >= 200) chk("busyTimeout", 32'h0000_0000, 32'h0000_0001);
    endtask

    // Item set after init; c gives the settings that must survive
    task automatic chk_init(input logic [31:0] c);
        chk("displayCfg", {21'h0, cfg_of(c)}, {21'h0, displayCfg});
        chk("startLine", {26'h0, `LDRI_START_RST}, {26'h0, startLine});
        chk("column", {24'h0, `LDRI_COLUMN_RST}, {24'h0, column});
        chk("page", {28'h0, `LDRI_PAGE_RST}, {28'h0, page});
        chk("volume", {27'h0, `LDRI_VOLUME_RST}, {27'h0, volume});
    endtask

    task automatic shift(input logic [7:0] b, input int k);
        for (int i = 0; i < k; i++) begin
            @(posedge clock);
            serialStrobe <= 1'b1;
            serialBit <= b[7-i];
        end
        @(posedge clock);
        serialStrobe <= 1'b0;
        #1;
    endtask

    task automatic print_verdict;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ==================================================
    // Watchdog, far beyond the little over a thousand cycles the tests need
    initial begin
        #100000;
        chk("watchdog", 32'h0000_0000, 32'h0000_0001);
        print_verdict();
    end

    // ==================================================
    // Main sequence
    initial begin
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        u_host.pin_high();
        wait_idle(n);
        chk("busyLen", 32'h1, {31'h0, n >= INIT && n <= INIT + 4});
        chk_init(32'h0000_0000);
        chk("serialByte", 32'h0, {24'h0, serialByte});
        chk("biasHighVariant", 32'h1, {31'h0, cfgHv.biasHigh});
        u_host.xfer(1'b0, `LDRI_OFF_STATUS, 32'h0, q);
        chk("status", 32'h0000_0020, q);
        seed = 32'h0000_a62e;
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            w = (seed & MASK) | 32'h0000_0300;
            v = (i < 4) ? corner[i] : seed[20:16];
            wr(`LDRI_OFF_CTRL, w);
            wr(`LDRI_OFF_VOLUME, {27'h0, v});
            tick();
            chk("cfg", {21'h0, cfg_of(w)}, {21'h0, displayCfg});
            chk("volume", {27'h0, v}, {27'h0, volume});
            u_host.xfer(1'b0, `LDRI_OFF_CTRL, 32'h0, q);
            chk("ctrlRead", w, q);
        end
        // Every kept and cleared setting set before the software reset
        w = MASK;
        wr(`LDRI_OFF_CTRL, w);
        wr(`LDRI_OFF_START, 32'h0000_003F);
        wr(`LDRI_OFF_COLUMN, 32'h0000_0083);
        wr(`LDRI_OFF_PAGE, 32'h0000_0008);
        wr(`LDRI_OFF_VOLUME, 32'h0000_0010);
        wr(`LDRI_OFF_SWRST, 32'h0000_0001);
        tick();
        chk("swBusy", 32'h1, {31'h0, busy});
        chk("swResetActive", 32'h1, {31'h0, resetActive});
        wr(`LDRI_OFF_VOLUME, 32'h0000_001F);
        wait_idle(n);
        chk_init(w & ~32'h0000_0070);
        // Three bits of a serial byte, then the pin, then a full byte
        wr(`LDRI_OFF_VOLUME, 32'h0000_0015);
        shift(8'hE0, 3);
        u_host.pin_low();
        #1;
        chk("asyncVolume", 32'h0, {27'h0, volume});
        chk("asyncBusy", 32'h1, {31'h0, busy});
        tog = 0;
        nFr = 0;
        nSp = 0;
        prev = display_clock_output;
        prevFr = lcd_ac_frame_signal;
        // Held long enough to span one whole frame of 33 lines
        for (int i = 0; i < 1100; i++) begin
            tick();
            if (display_clock_output !== prev) tog++;
            if (lcd_ac_frame_signal !== prevFr) nFr++;
            if (common_start_pulse_output === 1'b1) nSp++;
            prev = display_clock_output;
            prevFr = lcd_ac_frame_signal;
        end
        chk("clockRuns", 32'h1, {31'h0, tog >= 4});
        chk("frameRuns", 32'h1, {31'h0, nFr >= 1});
        chk("startPulses", nFr, nSp);
        u_host.pin_high();
        wait_idle(n);
        chk_init(32'h0000_0000);
        shift(8'h5A, 8);
        chk("serialValid", 32'h1, {31'h0, serialValid});
        chk("serialByte", 32'h0000_005A, {24'h0, serialByte});
        // Standby first, supply off second
        wr(`LDRI_OFF_CTRL, 32'h0000_0310);
        wr(`LDRI_OFF_CTRL, 32'h0000_0010);
        tick();
        chk("standbyOff", {21'h0, cfg_of(32'h0000_0010)}, {21'h0, displayCfg});
        u_host.xfer(1'b0, 8'hF0, 32'h0, q);
        chk("unmapped", 32'h0000_0000, q);
        chk("hresp", 32'h0000_0000, {31'h0, hresp});
        print_verdict();
    end
endmodule
